// File: design/seek_defines.svh
`ifndef SEEK_DEFINES_SVH
`define SEEK_DEFINES_SVH

// command port map
`define ADDR_W        4
`define DATA_W        16
`define ADDR_SEEK     4'h0
`define ADDR_CLS      4'h1
`define ADDR_STATUS   4'h2
`define ADDR_PRESENT  4'h3
`define ADDR_NEWCYL   4'h4

// status word and clear-status field positions
`define STAT_BUSY     0
`define STAT_SKCHK    2
`define STAT_ATTN     7
`define CLS_ATTN_BIT  0

// cylinder range
`define CYL_W         10
`define MAX_CYL       10'h336

// timing
`define TIMER_W       28
`define CLK_KHZ       125000
`define T_UNLOAD_MS   1667
`define T_SEEK_MS     120
`define T_SETTLE_US   1300
`define CYC_UNLOAD    (`T_UNLOAD_MS * `CLK_KHZ)
`define CYC_SEEK      (`T_SEEK_MS * `CLK_KHZ)
`define CYC_SETTLE    ((`T_SETTLE_US * `CLK_KHZ + 999) / 1000)

`endif

// File: design/seek_pkg.sv
package seek_pkg;

    typedef enum logic [2:0] {
        ST_RETRACTED,
        ST_LOADING,
        ST_READY,
        ST_SEEKING,
        ST_SETTLING,
        ST_RETRACTING
    } pos_state_e;

    typedef struct packed {
        logic agc;
        logic carriage_back;
        logic interlock;
        logic destructive_write;
        logic timeout;
    } fault_s;

    typedef struct packed {
        logic forward;
        logic reverse;
        logic fine;
        logic positive;
    } drive_s;

endpackage

// File: design/timeout_timer.sv
`timescale 1ns/100ps
`include "seek_defines.svh"

module timeout_timer (
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                start,
    input  wire logic                cancel,
    input  wire logic [`TIMER_W-1:0] load,
    output logic                     running,
    output logic                     expired
);
    logic [`TIMER_W-1:0] count_r;

    // start wins over cancel so a restart in the cancel cycle is kept
    always_ff @(posedge clock) begin
        if (reset) begin
            count_r <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                count_r <= load;
                running <= 1'b1;
            end else if (cancel) begin
                running <= 1'b0;
            end else if (running) begin
                if (count_r <= `TIMER_W'(1)) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count_r <= count_r - `TIMER_W'(1);
                end
            end
        end
    end
endmodule

// File: design/cyl_pulse_gen.sv
`timescale 1ns/100ps

module cyl_pulse_gen (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pos_polarity,
    input  wire logic motion,
    input  wire logic track_center_detect,
    input  wire logic seek_start,
    output logic      cyl_pulse,
    output logic      step,
    output logic      first_inhibit
);
    logic pol_r;
    logic tcd_r;

    wire crossing = motion && (pos_polarity != pol_r);
    wire tcd_rise = track_center_detect && !tcd_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            pol_r         <= 1'b0;
            tcd_r         <= 1'b0;
            first_inhibit <= 1'b0;
            cyl_pulse     <= 1'b0;
            step          <= 1'b0;
        end else begin
            pol_r     <= pos_polarity;
            tcd_r     <= track_center_detect;
            cyl_pulse <= crossing;
            step      <= crossing && !first_inhibit;
            if (seek_start)
                first_inhibit <= 1'b1;
            else if (tcd_rise)
                first_inhibit <= 1'b0;
        end
    end
endmodule

// File: design/disc_seek_unload_control.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "seek_defines.svh"

// Function
// - retract attention flip-flop set drives attention status bit 7 high.
// - clear-status with control bit 0 clears the attention bit.
// - access-ready dropping in unload sets busy, blocks seeks, holds attention.
// - retract plus carriage fully back cancels 1667 ms timeout, drops servo enable.
// - carriage back plus stop request raises run spindle low-active output.
// - door unlocks only after spindle stops; heads stay retracted until load.
// - seek accepted only with access-ready and settled both low.
// - seek starts 120 ms timeout, sets first inhibit, loads legal address.
// - seek pulses seek-check-clear, clearing seek check status bit 2.
// - seek pulses clear-offset low to zero stored offset.
// - address LSB drives phase select, high for odd cylinders.
// - inverted three address MSBs drive the write current selects.
// - compare new and present cylinder into 10-bit difference and direction.
// - below target drives forward and counts up; above drives reverse down.
// - velocity drive only when unmatched, not inhibited, not home, not retracting.
// - equal addresses select fine positioning.
// - current limiter enabled while seek inhibit active.
// - access-ready dropping on a seek sets busy and resets both attentions.
// - one cylinder pulse per position zero crossing during motion.
// - first pulse suppressed until track-center rising edge clears inhibit.
// - track-center input counts toward settling only while the addresses are equal.
// - retract on stop, any fault, timeout, or spindle speed loss.
// - after track centre in fine mode wait 1.3 ms before access-ready.
module disc_seek_unload_control #(
    parameter logic [`TIMER_W-1:0] UNLOAD_CYCLES = `TIMER_W'(`CYC_UNLOAD),
    parameter logic [`TIMER_W-1:0] SEEK_CYCLES   = `TIMER_W'(`CYC_SEEK),
    parameter logic [`TIMER_W-1:0] SETTLE_CYCLES = `TIMER_W'(`CYC_SETTLE)
) (
    input  wire logic                CLOCK,
    input  wire logic                RESET,
    input  wire logic [`ADDR_W-1:0]  ADDR,
    input  wire logic [`DATA_W-1:0]  WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output logic      [`DATA_W-1:0]  RDATA,
    input  wire logic                STOP_REQ,
    input  seek_pkg::fault_s         FAULTS,
    input  wire logic                SPEED_LOST,
    input  wire logic                CARRIAGE_FULLY_BACK,
    input  wire logic                TRACK_CENTER_DETECT,
    input  wire logic                POS_POLARITY,
    input  wire logic                SEEK_INHIBIT_SIG,
    input  wire logic                SEEK_HOME_CMD,
    input  wire logic                SEEK_CHECK_EVENT,
    input  wire logic                SPINDLE_STOPPED,
    input  wire logic                HEAD_LOAD_START,
    output logic                     ACCESS_READY_N,
    output logic                     HEADS_SETTLED_N,
    output logic                     RETRACT_REQUEST,
    output logic                     SERVO_ENABLE_SIG,
    output logic                     RUN_SPINDLE_N,
    output logic                     DOOR_UNLOCK,
    output logic                     SEEK_CHECK_CLEAR,
    output logic                     CLEAR_OFFSET_N,
    output logic                     PHASE_SELECT,
    output logic                     WRITE_CURRENT_SEL_A_N,
    output logic                     WRITE_CURRENT_SEL_B_N,
    output logic                     WRITE_CURRENT_SEL_C_N,
    output seek_pkg::drive_s         DRIVE,
    output logic      [`CYL_W-1:0]   CYL_DIFF,
    output logic                     CURRENT_LIMIT_EN,
    output logic                     CYL_CLOCK
);
    import seek_pkg::*;

    pos_state_e          state_r;
    pos_state_e          state_nxt;
    logic [`CYL_W-1:0]   new_cyl_r;
    logic [`CYL_W-1:0]   present_cyl_r;
    logic                retract_r;
    logic                access_ready_n_r;
    logic                heads_settled_n_r;
    logic                access_ready_n_attn_r;
    logic                ret_attn_r;
    logic                attn_hold_r;
    logic                seek_check_r;
    logic                timeout_fault_r;
    logic                servo_en_r;
    logic                run_spindle_n_r;
    logic                door_r;
    logic                seek_check_clear_r;
    logic                clear_offset_n_r;
    logic                phase_r;
    logic [2:0]          wsel_n_r;
    drive_s              drive_r;
    drive_s              drive_nxt;
    logic [`CYL_W-1:0]   cyl_diff_r;
    logic                limit_r;
    logic [`DATA_W-1:0]  rdata_r;
    logic [`DATA_W-1:0]  status_word;
    logic                main_running;
    logic                main_expired;
    logic                settle_expired;
    logic                step;
    logic                cyl_pulse;
    logic                first_inhibit;

    function automatic logic [`CYL_W-1:0] cyl_distance(input logic [`CYL_W-1:0] a, input logic [`CYL_W-1:0] b);
        cyl_distance = (a > b) ? `CYL_W'(a - b) : `CYL_W'(b - a);
    endfunction

    // command decode
    wire seek_cmd         = WR && (ADDR == `ADDR_SEEK);
    wire cls_cmd          = WR && (ADDR == `ADDR_CLS);
    wire illegal_cyl_addr = WDATA[`CYL_W-1:0] > `MAX_CYL;
    wire seek_decoded     = seek_cmd && (state_r == ST_READY)
                            && !access_ready_n_r && !heads_settled_n_r;

    // retract sources; the internal timeout is sticky and blocks head load, so only reset clears it
    wire retract_nxt  = STOP_REQ || (|FAULTS) || timeout_fault_r || SPEED_LOST;
    wire retract_rise = retract_nxt && !retract_r;
    wire load_start   = HEAD_LOAD_START && (state_r == ST_RETRACTED) && !retract_nxt;
    wire back_stop    = retract_r && CARRIAGE_FULLY_BACK;

    wire fine_pos  = (present_cyl_r == new_cyl_r);
    wire on_center = TRACK_CENTER_DETECT && fine_pos;

    wire access_ready_n_nxt = (state_nxt != ST_READY);
    wire access_ready_n_set   = access_ready_n_r && !access_ready_n_nxt;
    wire access_ready_n_drop  = !access_ready_n_r && access_ready_n_nxt;
    wire attn_reset = access_ready_n_drop && !retract_nxt;
    wire attn_clear = cls_cmd && WDATA[`CLS_ATTN_BIT];

    wire settle_enter = (state_nxt == ST_SETTLING) && (state_r != ST_SETTLING);
    wire settle_abort = (state_r == ST_SETTLING) && (state_nxt != ST_SETTLING);
    wire main_start   = seek_decoded || retract_rise;
    wire main_cancel  = access_ready_n_set || back_stop;
    wire [`TIMER_W-1:0] main_load = retract_rise ? UNLOAD_CYCLES : SEEK_CYCLES;

    wire motion_ok = !SEEK_INHIBIT_SIG && !SEEK_HOME_CMD && !retract_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RETRACTED:  if (load_start) state_nxt = ST_LOADING;
            ST_LOADING:    if (on_center) state_nxt = ST_SETTLING;
            ST_SEEKING:    if (on_center) state_nxt = ST_SETTLING;
            ST_SETTLING:   if (settle_expired) state_nxt = ST_READY;
            ST_READY:      if (seek_decoded) state_nxt = ST_SEEKING;
            ST_RETRACTING: if (CARRIAGE_FULLY_BACK) state_nxt = ST_RETRACTED;
        endcase
        if (retract_nxt && (state_r != ST_RETRACTED) && (state_r != ST_RETRACTING))
            state_nxt = ST_RETRACTING;
    end

    always_comb begin
        drive_nxt          = drive_r;
        drive_nxt.forward  = (present_cyl_r < new_cyl_r) && motion_ok;
        drive_nxt.reverse  = (present_cyl_r > new_cyl_r) && motion_ok;
        drive_nxt.fine     = fine_pos && !retract_nxt;
        if (present_cyl_r < new_cyl_r)
            drive_nxt.positive = 1'b1;
        else if (present_cyl_r > new_cyl_r)
            drive_nxt.positive = 1'b0;
    end

    always_comb begin
        status_word              = '0;
        status_word[`STAT_BUSY]  = access_ready_n_r;
        status_word[`STAT_SKCHK] = seek_check_r;
        status_word[`STAT_ATTN]  = access_ready_n_attn_r || ret_attn_r;
    end

    wire [`DATA_W-1:0] rd_word = (ADDR == `ADDR_STATUS)  ? status_word :
                                 (ADDR == `ADDR_PRESENT) ? `DATA_W'(present_cyl_r) :
                                 (ADDR == `ADDR_NEWCYL)  ? `DATA_W'(new_cyl_r) : '0;

    timeout_timer u_main_timer (
        .clock   (CLOCK),
        .reset   (RESET),
        .start   (main_start),
        .cancel  (main_cancel),
        .load    (main_load),
        .running (main_running),
        .expired (main_expired)
    );

    timeout_timer u_settle_timer (
        .clock   (CLOCK),
        .reset   (RESET),
        .start   (settle_enter),
        .cancel  (settle_abort),
        .load    (SETTLE_CYCLES),
        .running (),
        .expired (settle_expired)
    );

    cyl_pulse_gen u_pulse (
        .clock         (CLOCK),
        .reset         (RESET),
        .pos_polarity  (POS_POLARITY),
        .motion        (state_r == ST_SEEKING),
        .track_center_detect           (TRACK_CENTER_DETECT),
        .seek_start    (seek_decoded),
        .cyl_pulse     (cyl_pulse),
        .step          (step),
        .first_inhibit (first_inhibit)
    );

    // sequencing state; everything clears at reset with the heads retracted
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_r           <= ST_RETRACTED;
            retract_r         <= 1'b0;
            access_ready_n_r  <= 1'b1;
            heads_settled_n_r <= 1'b1;
            timeout_fault_r   <= 1'b0;
        end else begin
            state_r           <= state_nxt;
            retract_r         <= retract_nxt;
            access_ready_n_r  <= access_ready_n_nxt;
            heads_settled_n_r <= !((state_nxt == ST_SETTLING) || (state_nxt == ST_READY));
            if (main_expired)
                timeout_fault_r <= 1'b1;
            else if (load_start)
                timeout_fault_r <= 1'b0;
        end
    end

    // attention flip-flops: a set in the clearing cycle wins
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            access_ready_n_attn_r  <= 1'b0;
            ret_attn_r   <= 1'b0;
            attn_hold_r  <= 1'b0;
            seek_check_r <= 1'b0;
        end else begin
            if (access_ready_n_drop)
                attn_hold_r <= retract_nxt;
            access_ready_n_attn_r  <= access_ready_n_set || (access_ready_n_attn_r && !attn_clear && !attn_reset);
            ret_attn_r   <= retract_rise || (ret_attn_r && !attn_clear && !attn_reset);
            seek_check_r <= SEEK_CHECK_EVENT || (seek_check_r && !seek_check_clear_r);
        end
    end

    // cylinder address and counter
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            new_cyl_r     <= '0;
            present_cyl_r <= '0;
        end else if (load_start) begin
            new_cyl_r     <= '0;
            present_cyl_r <= '0;
        end else begin
            if (seek_decoded && !illegal_cyl_addr)
                new_cyl_r <= WDATA[`CYL_W-1:0];
            if (step && !fine_pos)
                present_cyl_r <= drive_r.positive ? `CYL_W'(present_cyl_r + 1'b1)
                                                  : `CYL_W'(present_cyl_r - 1'b1);
        end
    end

    // loop, spindle and door
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            servo_en_r      <= 1'b0;
            run_spindle_n_r <= 1'b1;
            door_r          <= 1'b0;
        end else begin
            if (back_stop)
                servo_en_r <= 1'b0;
            else if (load_start)
                servo_en_r <= 1'b1;
            if (CARRIAGE_FULLY_BACK && STOP_REQ)
                run_spindle_n_r <= 1'b1;
            else if (load_start)
                run_spindle_n_r <= 1'b0;
            // unlocking with the spindle still coasting would expose a spinning pack
            door_r <= (state_nxt == ST_RETRACTED) && run_spindle_n_r && SPINDLE_STOPPED;
        end
    end

    // registered outputs toward the servo and write electronics
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            seek_check_clear_r <= 1'b0;
            clear_offset_n_r   <= 1'b1;
            phase_r            <= 1'b0;
            wsel_n_r           <= 3'h7;
            drive_r            <= '0;
            cyl_diff_r         <= '0;
            limit_r            <= 1'b0;
            rdata_r            <= '0;
        end else begin
            seek_check_clear_r <= seek_decoded;
            clear_offset_n_r   <= !(seek_decoded || load_start);
            phase_r            <= new_cyl_r[0];
            wsel_n_r           <= ~new_cyl_r[`CYL_W-1:`CYL_W-3];
            drive_r            <= drive_nxt;
            cyl_diff_r         <= cyl_distance(new_cyl_r, present_cyl_r);
            limit_r            <= SEEK_INHIBIT_SIG;
            rdata_r            <= RD ? rd_word : '0;
        end
    end

    assign RDATA                 = rdata_r;
    assign ACCESS_READY_N        = access_ready_n_r;
    assign HEADS_SETTLED_N       = heads_settled_n_r;
    assign RETRACT_REQUEST       = retract_r;
    assign SERVO_ENABLE_SIG      = servo_en_r;
    assign RUN_SPINDLE_N         = run_spindle_n_r;
    assign DOOR_UNLOCK           = door_r;
    assign SEEK_CHECK_CLEAR      = seek_check_clear_r;
    assign CLEAR_OFFSET_N        = clear_offset_n_r;
    assign PHASE_SELECT          = phase_r;
    assign WRITE_CURRENT_SEL_A_N = wsel_n_r[2];
    assign WRITE_CURRENT_SEL_B_N = wsel_n_r[1];
    assign WRITE_CURRENT_SEL_C_N = wsel_n_r[0];
    assign DRIVE                 = drive_r;
    assign CYL_DIFF              = cyl_diff_r;
    assign CURRENT_LIMIT_EN      = limit_r;
    assign CYL_CLOCK             = cyl_pulse;

    property p_retract_attn;
        @(posedge CLOCK) disable iff (RESET) $rose(retract_r) |-> ret_attn_r;
    endproperty
    a_retract_attn: assert property (p_retract_attn) else $error("retract attention not set");

    property p_cls_clear;
        @(posedge CLOCK) disable iff (RESET)
            attn_clear && !access_ready_n_set && !retract_rise |=> !status_word[`STAT_ATTN];
    endproperty
    a_cls_clear: assert property (p_cls_clear) else $error("attention survived clear");

    property p_unload_hold;
        @(posedge CLOCK) disable iff (RESET)
            $rose(access_ready_n_r) && retract_r |-> attn_hold_r && status_word[`STAT_BUSY];
    endproperty
    a_unload_hold: assert property (p_unload_hold) else $error("unload did not hold attention");

    property p_back_stop;
        @(posedge CLOCK) disable iff (RESET)
            retract_r && CARRIAGE_FULLY_BACK && !retract_rise |=> !servo_en_r && !main_running;
    endproperty
    a_back_stop: assert property (p_back_stop) else $error("servo or timeout still on");

    property p_spindle_stop;
        @(posedge CLOCK) disable iff (RESET) CARRIAGE_FULLY_BACK && STOP_REQ |=> RUN_SPINDLE_N;
    endproperty
    a_spindle_stop: assert property (p_spindle_stop) else $error("spindle not stopped");

    property p_seek_refused;
        @(posedge CLOCK) disable iff (RESET)
            seek_cmd && (access_ready_n_r || heads_settled_n_r) && !load_start |=> $stable(new_cyl_r);
    endproperty
    a_seek_refused: assert property (p_seek_refused) else $error("seek taken while busy");

    property p_seek_effects;
        @(posedge CLOCK) disable iff (RESET)
            seek_decoded |=> first_inhibit && SEEK_CHECK_CLEAR && !CLEAR_OFFSET_N
                             ##1 !SEEK_CHECK_CLEAR && CLEAR_OFFSET_N;
    endproperty
    a_seek_effects: assert property (p_seek_effects) else $error("seek side effects wrong");

    property p_seek_busy;
        @(posedge CLOCK) disable iff (RESET)
            seek_decoded |=> ACCESS_READY_N && !status_word[`STAT_ATTN];
    endproperty
    a_seek_busy: assert property (p_seek_busy) else $error("seek left ready or attention");

    property p_fine_excl;
        @(posedge CLOCK) disable iff (RESET) DRIVE.fine |-> !DRIVE.forward && !DRIVE.reverse;
    endproperty
    a_fine_excl: assert property (p_fine_excl) else $error("fine and velocity drive together");

    property p_first_inhibit;
        @(posedge CLOCK) disable iff (RESET) $past(first_inhibit) |-> !step;
    endproperty
    a_first_inhibit: assert property (p_first_inhibit) else $error("inhibited pulse stepped");
endmodule

// File: sim/mech_servo_model.sv
`timescale 1ns/100ps

module mech_servo_model (
    input  wire logic       clock,
    input  wire logic       reset,
    input  seek_pkg::drive_s drive,
    input  wire logic       retract,
    output logic            pos_polarity,
    output logic            track_center_detect,
    output logic            carriage_fully_back
);
    import seek_pkg::*;
    logic [2:0] phase_r = 3'h0;
    logic [2:0] back_r  = 3'h0;
    wire        moving  = drive.forward | drive.reverse;
    initial pos_polarity = 1'b0;
    // one zero crossing every six cycles while the carriage is driven
    always @(posedge clock) begin
        phase_r <= (reset || !moving || phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
        if (moving && phase_r == 3'h0)
            pos_polarity <= ~pos_polarity;
        back_r <= reset ? 3'h0 : {back_r[1:0], retract};
    end
    // near centre for two cycles starting one cycle after each crossing, and steadily once fine positioning holds
    assign track_center_detect = drive.fine | (moving & (phase_r[2:1] == 2'h1));
    assign carriage_fully_back = back_r[2];
endmodule

// File: sim/tb_disc_seek_unload_control.sv
`timescale 1ns/100ps
`include "seek_defines.svh"

module tb_disc_seek_unload_control;
    import seek_pkg::*;
    logic        CLOCK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, STOP_REQ = 1'b0, SPEED_LOST = 1'b0;
    logic        SPINDLE_STOPPED = 1'b0, HEAD_LOAD_START = 1'b0, SEEK_INHIBIT_SIG = 1'b0;
    logic        SEEK_CHECK_EVENT = 1'b0, SEEK_HOME_CMD = 1'b0;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000, RDATA, d;
    logic [9:0]  CYL_DIFF, cur, nc;
    fault_s      FAULTS = '0;
    drive_s      DRIVE;
    logic        ACCESS_READY_N, HEADS_SETTLED_N, RETRACT_REQUEST, SERVO_ENABLE_SIG, RUN_SPINDLE_N;
    logic        DOOR_UNLOCK, SEEK_CHECK_CLEAR, CLEAR_OFFSET_N, PHASE_SELECT, CURRENT_LIMIT_EN, CYL_CLOCK;
    logic        WRITE_CURRENT_SEL_A_N, WRITE_CURRENT_SEL_B_N, WRITE_CURRENT_SEL_C_N;
    logic        TRACK_CENTER_DETECT, POS_POLARITY, CARRIAGE_FULLY_BACK;
    int          bad_count = 0, n_compared = 0, cycles = 0, pulses = 0, n0 = 0;
    logic [9:0]  tgt [4] = '{10'h005, 10'h002, 10'h300, 10'h3FF};

    disc_seek_unload_control #(.UNLOAD_CYCLES(28'h00000C8), .SEEK_CYCLES(28'h0001F40),
        .SETTLE_CYCLES(28'h0000014)) disc_seek_unload_control_inst (.*);
    mech_servo_model mech_servo_model_inst (.clock(CLOCK), .reset(RESET), .drive(DRIVE),
        .retract(RETRACT_REQUEST), .pos_polarity(POS_POLARITY), .track_center_detect(TRACK_CENTER_DETECT),
        .carriage_fully_back(CARRIAGE_FULLY_BACK));

    initial begin
        forever #4 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        v = RDATA;
    endtask

    // long seeks take about six cycles per cylinder, hence the generous bound
    task automatic wait_ready();
        for (int n = 0; n < 8000 && ACCESS_READY_N !== 1'b0; n++) begin
            @(posedge CLOCK);
            #1;
        end
        chk(ACCESS_READY_N, 1'b0);
        chk(HEADS_SETTLED_N, 1'b0);
    endtask

    // every cylinder clock, the inhibited first one included
    always @(posedge CLOCK) begin
        cycles++;
        if (CYL_CLOCK)
            pulses++;
        if (cycles == 30000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        HEAD_LOAD_START <= 1'b1;
        #1;
        chk(RUN_SPINDLE_N, 1'b1);
        @(posedge CLOCK);
        HEAD_LOAD_START <= 1'b0;
        wait_ready();
        wr(`ADDR_CLS, 16'h0001);
        rd(`ADDR_STATUS, d);
        chk(d & 16'h0080, 16'h0000);
        @(posedge CLOCK);
        SEEK_CHECK_EVENT <= 1'b1;
        @(posedge CLOCK);
        SEEK_CHECK_EVENT <= 1'b0;
        rd(`ADDR_STATUS, d);
        chk(d & 16'h0004, 16'h0004);
        cur = 10'h000;
        for (int i = 0; i < 4; i++) begin
            nc = (tgt[i] > `MAX_CYL) ? cur : tgt[i];
            n0 = pulses;
            wr(`ADDR_SEEK, {6'h00, tgt[i]});
            #1;
            chk({SEEK_CHECK_CLEAR, CLEAR_OFFSET_N, ACCESS_READY_N}, 3'b101);
            repeat (2) @(posedge CLOCK);
            #1;
            chk(PHASE_SELECT, nc[0]);
            chk({WRITE_CURRENT_SEL_A_N, WRITE_CURRENT_SEL_B_N, WRITE_CURRENT_SEL_C_N}, {~nc[9], ~nc[8], ~nc[7]});
            chk(CYL_DIFF, (nc > cur) ? nc - cur : cur - nc);
            chk({DRIVE.forward, DRIVE.reverse, DRIVE.fine}, {nc > cur, nc < cur, nc == cur});
            if (nc != cur)
                chk(DRIVE.positive, nc > cur);
            wait_ready();
            chk(16'(pulses - n0), (nc == cur) ? 16'h0000 : ((nc > cur) ? nc - cur : cur - nc) + 16'h0001);
            rd(`ADDR_PRESENT, d);
            chk(d, {6'h00, nc});
            rd(`ADDR_NEWCYL, d);
            chk(d, {6'h00, nc});
            rd(`ADDR_STATUS, d);
            chk(d & 16'h0085, 16'h0080);
            cur = nc;
        end
        @(posedge CLOCK);
        SEEK_INHIBIT_SIG <= 1'b1;
        @(posedge CLOCK);
        SEEK_INHIBIT_SIG <= 1'b0;
        #1;
        chk(CURRENT_LIMIT_EN, 1'b1);
        @(posedge CLOCK);
        STOP_REQ <= 1'b1;
        @(posedge CLOCK);
        #1;
        chk({RETRACT_REQUEST, SERVO_ENABLE_SIG, RUN_SPINDLE_N}, 3'b110);
        rd(`ADDR_STATUS, d);
        chk(d & 16'h0081, 16'h0081);
        chk(ACCESS_READY_N, 1'b1);
        repeat (4) @(posedge CLOCK);
        #1;
        chk({SERVO_ENABLE_SIG, RUN_SPINDLE_N, DOOR_UNLOCK}, 3'b010);
        @(posedge CLOCK);
        SPINDLE_STOPPED <= 1'b1;
        repeat (2) @(posedge CLOCK);
        #1;
        chk(DOOR_UNLOCK, 1'b1);
        // heads are parked, so this seek must leave the stored address alone
        wr(`ADDR_SEEK, 16'h0001);
        rd(`ADDR_NEWCYL, d);
        chk(d, 16'h0300);
        wrap_up();
    end
endmodule
